// *** core/ebpg_defs.svh ***
`ifndef EBPG_DEFS_SVH
`define EBPG_DEFS_SVH
// ****************************************************************
// address and record field layout
// ****************************************************************
`define EBPG_ADDR_W 63
`define EBPG_SRC_PREDICTED_BIT 63
`define EBPG_FILTER_W 9
`define EBPG_FILTER_FAR_BIT 8
`define EBPG_STATUS_W 64
`define EBPG_STATUS_INTERFERENCE_BIT 60
`define EBPG_GEN_COUNTERS 4
`define EBPG_FIXED_COUNTERS 3
`endif

// *** core/ebpg_pkg.sv ***
package ebpg_pkg;
	// kind of record pushed onto the branch stack
	typedef enum logic [1:0] {EBPG_REC_NONE, EBPG_REC_ENTRY, EBPG_REC_EXIT,
		EBPG_REC_ASYNC} ebpg_rec_e;
	// enclave residency of this logical processor
	typedef enum logic [1:0] {EBPG_OUTSIDE, EBPG_IN_OPTIN, EBPG_IN_OPTOUT} ebpg_mode_e;
	// pending record stage during an asynchronous exit
	typedef enum logic [1:0] {EBPG_AX_IDLE, EBPG_AX_EVENT} ebpg_ax_e;
endpackage

// *** core/ebpg_gating.sv ***
`include "ebpg_defs.svh"
// ****************************************************************
// enclave branch record and monitoring gate
// ****************************************************************
// Functional notes
// - opt-out entry suppresses branch recording; exit afterwards lifts it
// - opt-out entry pushes no branch record itself
// - exit after recorded opt-out entry pushes one record: entry address to exit target
// - async exit after opt-out pushes entry-to-pointer record before the event's record
// - causing event's own record takes async exit pointer as its source
// - every enclave record is predicted; source bit 63 set
// - enclave records are tagged outside lock elision and restricted transactions
// - enclave transfers are far branches, filtered by filter select bit 8
// - interference flag sits at status bit 60
// - opt-in entry leaves counting, sampling and bit 60 untouched
// - opt-out entry stops fixed counter zero and general counters, not cycles
// - opt-out entry suppresses precise sampling and sets bit 60
// - sibling all-thread counters demoted to own-thread while opt-out enclave runs
// - any enclave exit lifts all monitoring suppression on this thread
// - enclave exit restores demoted sibling counters to all-thread
// - supervisor ops and key/report leaves report their own address as event ip
// - opt-in entry reports its address; opt-out entry produces no sample
// - sample pending at exit reports exit address or last entry address
// - sample pending after async exit reports saved address or last entry address
// - second sample taken after exiting event reports async exit pointer
// - opt-in with recording pushes a record for each enclave branch the far filter keeps
module ebpg_gating
	import ebpg_pkg::*;
(
	input wire logic mclk, // core clock
	input wire logic reset_n, // async reset, active low
	input wire logic enterValid, // enter or resume retires
	input wire logic enterOptOut, // entry is opt-out
	input wire logic [`EBPG_ADDR_W-1:0] enterIp, // entering instruction address
	input wire logic [`EBPG_ADDR_W-1:0] enterTarget, // entry destination
	input wire logic exitValid, // exit leaf retires
	input wire logic [`EBPG_ADDR_W-1:0] exitIp, // exit instruction address
	input wire logic [`EBPG_ADDR_W-1:0] exitTarget, // exit destination
	input wire logic asyncValid, // asynchronous exit happens
	input wire logic [`EBPG_ADDR_W-1:0] asyncPointer, // async exit pointer
	input wire logic [`EBPG_ADDR_W-1:0] saveAreaIp, // address saved in state save area
	input wire logic eventPushes, // causing event pushes a record
	input wire logic [`EBPG_ADDR_W-1:0] eventTarget, // causing event destination
	input wire logic branchValid, // branch retires inside enclave
	input wire logic [`EBPG_ADDR_W-1:0] branchIp, // branch source
	input wire logic [`EBPG_ADDR_W-1:0] branchTarget, // branch destination
	input wire logic branchFar, // branch is far
	input wire logic leafValid, // other enclave leaf retires
	input wire logic leafSupervisor, // leaf is a supervisor op
	input wire logic leafKeyOrReport, // user leaf is key fetch or report
	input wire logic [`EBPG_ADDR_W-1:0] leafIp, // leaf instruction address
	input wire logic sampleDue, // precise event pending at boundary
	input wire logic eeeSampleDue, // second event at end of exiting event
	input wire logic recordEnable, // branch recording enabled
	input wire logic [`EBPG_FILTER_W-1:0] branchFilterSelect, // filter bits, set = drop
	input wire logic siblingOptOut, // sibling runs an opt-out enclave
	input wire logic [`EBPG_GEN_COUNTERS-1:0] siblingAllThread, // sibling general all_thread_count
	input wire logic [`EBPG_FIXED_COUNTERS-1:0] siblingFixedAllThread, // sibling fixed all-thread
	input wire logic statusClear, // software clears the flag
	output logic recPush, // branch record push strobe
	output logic [63:0] branchSourceSlot, // record source incl. predicted bit
	output logic [63:0] branchTargetSlot, // record target
	output logic recInTransaction, // record inside elision/transaction
	output logic samplePush, // precise record strobe
	output logic [`EBPG_ADDR_W-1:0] eventIp, // event ip of the record
	output logic [`EBPG_STATUS_W-1:0] globalCounterStatus, // status word
	output logic fixedZeroEnable, // fixed_counter_zero may count
	output logic [`EBPG_GEN_COUNTERS-1:0] generalEnable, // general_counter_x may count
	output logic cycleCountEnable, // fixed one and two always count
	output logic samplingSuppressed, // precise sampling off for thread
	output logic [`EBPG_GEN_COUNTERS-1:0] siblingEffAllThread, // sibling general, after demotion
	output logic [`EBPG_FIXED_COUNTERS-1:0] siblingFixedEffAll, // sibling fixed, after demotion
	output ebpg_mode_e enclaveMode // current residency
);
	// ****************************************************************
	// thread state
	// ****************************************************************
	ebpg_mode_e mode_reg, mode_next;
	logic [`EBPG_ADDR_W-1:0] entryIp_reg, entryIp_next;
	logic recAtEntry_reg, recAtEntry_next;
	logic flag_reg, flag_next;
	ebpg_ax_e ax_reg, ax_next;
	logic [`EBPG_ADDR_W-1:0] axPtr_reg, axPtr_next, axTgt_reg, axTgt_next;
	logic push_reg, push_next, samp_reg, samp_next;
	logic [`EBPG_ADDR_W-1:0] src_reg, src_next, tgt_reg, tgt_next, eip_reg, eip_next;

	// far-branch filter: set bit drops the record
	function automatic logic farAllowed(input logic [`EBPG_FILTER_W-1:0] sel);
		farAllowed = !sel[`EBPG_FILTER_FAR_BIT];
	endfunction

	// next state; one transfer per cycle, async exit wins over others
	always_comb
	begin
		mode_next = mode_reg;
		entryIp_next = entryIp_reg;
		recAtEntry_next = recAtEntry_reg;
		flag_next = flag_reg;
		ax_next = EBPG_AX_IDLE;
		axPtr_next = axPtr_reg;
		axTgt_next = axTgt_reg;
		push_next = 1'b0;
		samp_next = 1'b0;
		src_next = src_reg;
		tgt_next = tgt_reg;
		eip_next = eip_reg;
		// flag: software clear loses to a new opt-out entry
		if (statusClear)
			flag_next = 1'b0;
		if (ax_reg == EBPG_AX_EVENT)
		begin
			// event record follows the async exit record (entry or saved address to pointer) one cycle later
			push_next = recordEnable && farAllowed(branchFilterSelect);
			src_next = axPtr_reg;
			tgt_next = axTgt_reg;
			samp_next = eeeSampleDue;
			eip_next = axPtr_reg;
		end
		else if (asyncValid && mode_reg != EBPG_OUTSIDE)
		begin
			mode_next = EBPG_OUTSIDE;
			axPtr_next = asyncPointer;
			axTgt_next = eventTarget;
			if (eventPushes)
				ax_next = EBPG_AX_EVENT;
			if (mode_reg == EBPG_IN_OPTOUT)
			begin
				push_next = recAtEntry_reg && farAllowed(branchFilterSelect);
				src_next = entryIp_reg;
				eip_next = entryIp_reg;
			end
			else
			begin
				push_next = recordEnable && farAllowed(branchFilterSelect);
				src_next = saveAreaIp;
				eip_next = saveAreaIp;
			end
			tgt_next = asyncPointer;
			samp_next = sampleDue;
		end
		else if (exitValid && mode_reg != EBPG_OUTSIDE)
		begin
			mode_next = EBPG_OUTSIDE;
			if (mode_reg == EBPG_IN_OPTOUT)
			begin
				push_next = recAtEntry_reg && farAllowed(branchFilterSelect);
				src_next = entryIp_reg;
				eip_next = entryIp_reg;
			end
			else
			begin
				push_next = recordEnable && farAllowed(branchFilterSelect);
				src_next = exitIp;
				eip_next = exitIp;
			end
			tgt_next = exitTarget;
			samp_next = sampleDue;
		end
		else if (enterValid)
		begin
			entryIp_next = enterIp;
			recAtEntry_next = recordEnable;
			src_next = enterIp;
			tgt_next = enterTarget;
			eip_next = enterIp;
			if (enterOptOut)
			begin
				mode_next = EBPG_IN_OPTOUT;
				flag_next = 1'b1;
			end
			else
			begin
				mode_next = EBPG_IN_OPTIN;
				push_next = recordEnable && farAllowed(branchFilterSelect);
				samp_next = sampleDue;
			end
		end
		else if (leafValid && (leafSupervisor || leafKeyOrReport))
		begin
			// opt-out user leaves are never sampled
			samp_next = sampleDue && (leafSupervisor || mode_reg != EBPG_IN_OPTOUT);
			eip_next = leafIp;
		end
		else if (branchValid && mode_reg == EBPG_IN_OPTIN)
		begin
			push_next = recordEnable && (farAllowed(branchFilterSelect) || !branchFar);
			src_next = branchIp;
			tgt_next = branchTarget;
		end
	end

	// registers only
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mode_reg <= EBPG_OUTSIDE;
			entryIp_reg <= 63'h0000_0000_0000_0000;
			recAtEntry_reg <= 1'b0;
			flag_reg <= 1'b0;
			ax_reg <= EBPG_AX_IDLE;
			axPtr_reg <= 63'h0000_0000_0000_0000;
			axTgt_reg <= 63'h0000_0000_0000_0000;
			push_reg <= 1'b0;
			samp_reg <= 1'b0;
			src_reg <= 63'h0000_0000_0000_0000;
			tgt_reg <= 63'h0000_0000_0000_0000;
			eip_reg <= 63'h0000_0000_0000_0000;
		end
		else
		begin
			mode_reg <= mode_next;
			entryIp_reg <= entryIp_next;
			recAtEntry_reg <= recAtEntry_next;
			flag_reg <= flag_next;
			ax_reg <= ax_next;
			axPtr_reg <= axPtr_next;
			axTgt_reg <= axTgt_next;
			push_reg <= push_next;
			samp_reg <= samp_next;
			src_reg <= src_next;
			tgt_reg <= tgt_next;
			eip_reg <= eip_next;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign recPush = push_reg;
	assign branchSourceSlot = {1'b1, src_reg};
	assign branchTargetSlot = {1'b0, tgt_reg};
	assign recInTransaction = 1'b0;
	assign samplePush = samp_reg;
	assign eventIp = eip_reg;
	// only the flag bit is owned here; others read zero
	always_comb
	begin
		globalCounterStatus = 64'h0000_0000_0000_0000;
		globalCounterStatus[`EBPG_STATUS_INTERFERENCE_BIT] = flag_reg;
	end
	// suppression follows residency so exit lifts it the next cycle
	assign fixedZeroEnable = mode_reg != EBPG_IN_OPTOUT;
	assign generalEnable = {`EBPG_GEN_COUNTERS{mode_reg != EBPG_IN_OPTOUT}};
	assign cycleCountEnable = 1'b1;
	assign samplingSuppressed = mode_reg == EBPG_IN_OPTOUT;
	// demotion is live: clears as soon as the sibling leaves its enclave
	assign siblingEffAllThread = siblingAllThread
		& {`EBPG_GEN_COUNTERS{!siblingOptOut}};
	assign siblingFixedEffAll = siblingFixedAllThread
		& {`EBPG_FIXED_COUNTERS{!siblingOptOut}};
	assign enclaveMode = mode_reg;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// opt-out residency: silent branch stack, gated counters, raised flag
	optout_nopush_a: assert property (
		enterValid && enterOptOut && !exitValid && !asyncValid && mode_reg == EBPG_OUTSIDE
		|=> !recPush)
		else $error("opt-out entry pushed");
	optout_flag_a: assert property (
		enterValid && enterOptOut && mode_reg == EBPG_OUTSIDE
		|=> globalCounterStatus[60])
		else $error("flag not set");
	optout_stop_a: assert property (
		mode_reg == EBPG_IN_OPTOUT
		|-> !fixedZeroEnable && generalEnable == '0 && cycleCountEnable)
		else $error("counting not gated");
	optout_norec_a: assert property (
		mode_reg == EBPG_IN_OPTOUT && ax_reg == EBPG_AX_IDLE
		&& !enterValid && !exitValid && !asyncValid
		|=> !recPush)
		else $error("record pushed inside opt-out enclave");

	// records built on leaving an opt-out enclave, record tagging, suppression lifted on exit
	exit_src_a: assert property (
		exitValid && !asyncValid && ax_reg == EBPG_AX_IDLE && mode_reg == EBPG_IN_OPTOUT
		&& recAtEntry_reg && !branchFilterSelect[8]
		|=> recPush && branchSourceSlot[62:0] == $past(entryIp_reg))
		else $error("exit record wrong");
	async_first_a: assert property (
		asyncValid && ax_reg == EBPG_AX_IDLE && mode_reg == EBPG_IN_OPTOUT
		&& recAtEntry_reg && !branchFilterSelect[8]
		|=> recPush && branchSourceSlot[62:0] == $past(entryIp_reg)
		&& branchTargetSlot[62:0] == $past(asyncPointer))
		else $error("async entry record wrong");
	async_order_a: assert property (
		ax_reg == EBPG_AX_IDLE && asyncValid && mode_reg == EBPG_IN_OPTOUT && eventPushes
		|=> ##1 branchSourceSlot[62:0] == $past(asyncPointer, 2))
		else $error("event record source wrong");
	predicted_a: assert property (
		recPush |-> branchSourceSlot[63] && !recInTransaction)
		else $error("record not predicted");
	exit_unsup_a: assert property (
		exitValid && mode_reg != EBPG_OUTSIDE && ax_reg == EBPG_AX_IDLE
		|=> !samplingSuppressed && fixedZeroEnable)
		else $error("suppression held");

	// opt-in residency stays fully observable; sibling demotion
	optin_branch_a: assert property (
		branchValid && mode_reg == EBPG_IN_OPTIN && ax_reg == EBPG_AX_IDLE && recordEnable
		&& !branchFar && !enterValid && !exitValid && !asyncValid && !leafValid
		|=> recPush && branchSourceSlot[62:0] == $past(branchIp))
		else $error("enclave branch not recorded");
	demote_a: assert property (
		siblingOptOut |-> siblingEffAllThread == '0 && siblingFixedEffAll == '0)
		else $error("sibling not demoted");
	optin_flag_a: assert property (
		mode_reg == EBPG_IN_OPTIN && $past(mode_reg) == EBPG_OUTSIDE && !$past(flag_reg)
		|-> !globalCounterStatus[60])
		else $error("flag set on opt-in");
	async_cov: cover property (asyncValid && mode_reg == EBPG_IN_OPTOUT ##1 recPush);
	exit_cov: cover property (exitValid && mode_reg == EBPG_IN_OPTIN ##1 samplePush);
	optout_cov: cover property (enterValid && enterOptOut ##[1:5] exitValid);
	clash_cov: cover property (enterValid && enterOptOut && statusClear ##1 globalCounterStatus[60]);
	leaf_cov: cover property (leafValid && leafKeyOrReport ##1 samplePush);
endmodule // ebpg_gating

// *** testbench/ebpg_gating_bench.sv ***
`include "ebpg_defs.svh"
module ebpg_gating_bench
	import ebpg_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************************************
	// stimulus and observed signals
	// ****************************************************************
	logic mclk, reset_n, enterValid, enterOptOut, exitValid, asyncValid, eventPushes;
	logic branchValid, branchFar, leafValid, leafSupervisor, leafKeyOrReport, sampleDue;
	logic eeeSampleDue, recordEnable, siblingOptOut, statusClear;
	logic [`EBPG_ADDR_W-1:0] enterIp, enterTarget, exitIp, exitTarget, asyncPointer, saveAreaIp;
	logic [`EBPG_ADDR_W-1:0] eventTarget, branchIp, branchTarget, leafIp, eventIp;
	logic [`EBPG_FILTER_W-1:0] branchFilterSelect;
	logic [3:0] siblingAllThread, generalEnable, siblingEffAllThread;
	logic [2:0] siblingFixedAllThread, siblingFixedEffAll;
	logic recPush, recInTransaction, samplePush, fixedZeroEnable, cycleCountEnable;
	logic samplingSuppressed;
	logic [63:0] branchSourceSlot, branchTargetSlot, globalCounterStatus;
	ebpg_mode_e enclaveMode;
	int n_errors, total_checks, cycles;
	ebpg_gating DUT (.mclk(mclk), .reset_n(reset_n), .enterValid(enterValid),
		.enterOptOut(enterOptOut), .enterIp(enterIp), .enterTarget(enterTarget),
		.exitValid(exitValid), .exitIp(exitIp), .exitTarget(exitTarget), .asyncValid(asyncValid),
		.asyncPointer(asyncPointer), .saveAreaIp(saveAreaIp), .eventPushes(eventPushes),
		.eventTarget(eventTarget), .branchValid(branchValid), .branchIp(branchIp),
		.branchTarget(branchTarget), .branchFar(branchFar), .leafValid(leafValid),
		.leafSupervisor(leafSupervisor), .leafKeyOrReport(leafKeyOrReport), .leafIp(leafIp),
		.sampleDue(sampleDue), .eeeSampleDue(eeeSampleDue), .recordEnable(recordEnable),
		.branchFilterSelect(branchFilterSelect), .siblingOptOut(siblingOptOut),
		.siblingAllThread(siblingAllThread), .siblingFixedAllThread(siblingFixedAllThread),
		.statusClear(statusClear), .recPush(recPush), .branchSourceSlot(branchSourceSlot),
		.branchTargetSlot(branchTargetSlot), .recInTransaction(recInTransaction),
		.samplePush(samplePush), .eventIp(eventIp), .globalCounterStatus(globalCounterStatus),
		.fixedZeroEnable(fixedZeroEnable), .generalEnable(generalEnable),
		.cycleCountEnable(cycleCountEnable), .samplingSuppressed(samplingSuppressed),
		.siblingEffAllThread(siblingEffAllThread), .siblingFixedEffAll(siblingFixedEffAll),
		.enclaveMode(enclaveMode));
	// ****************************************************************
	// clock, watchdog and shared helpers
	// ****************************************************************
	initial
	begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	// a hang ends the run instead of stalling the simulator
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_errors++;
			tally_and_finish();
		end
	end
	task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// lets the request edge pass, drops pulses, samples once outputs settle
	task automatic tick();
		@(posedge mclk);
		{enterValid, exitValid, asyncValid, branchValid, leafValid, statusClear} <= 6'h00;
		#1;
	endtask
	task automatic enter(logic optOut, logic due);
		@(posedge mclk);
		enterValid <= 1;
		enterOptOut <= optOut;
		sampleDue <= due;
		tick();
	endtask
	task automatic rec(string what, logic [62:0] src, logic [62:0] dst);
		chk({what, " push"}, recPush, 1);
		chk({what, " src"}, branchSourceSlot, {1'b1, src});
		chk({what, " dst"}, branchTargetSlot, {1'b0, dst});
		chk({what, " tx"}, recInTransaction, 0);
	endtask
	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_optout_exit();
		enter(1, 1);
		chk("entry push", recPush, 0);
		chk("entry sample", samplePush, 0);
		chk("mode", enclaveMode, EBPG_IN_OPTOUT);
		chk("flag", globalCounterStatus[60], 1);
		chk("fix0", fixedZeroEnable, 0);
		chk("gen", generalEnable, 4'h0);
		chk("cyc", cycleCountEnable, 1);
		chk("precise_event_sampling off", samplingSuppressed, 1);
		@(posedge mclk);
		siblingOptOut <= 1;
		#1;
		chk("sib gen", siblingEffAllThread, 4'h0);
		chk("sib fix", siblingFixedEffAll, 3'h0);
		@(posedge mclk);
		siblingOptOut <= 0;
		#1;
		chk("sib back", siblingEffAllThread, 4'hF);
		chk("sib fix back", siblingFixedEffAll, 3'h7);
		@(posedge mclk);
		exitValid <= 1;
		tick();
		rec("exit", enterIp, exitTarget);
		chk("exit sample ip", {samplePush, eventIp}, {1'b1, enterIp});
		chk("fix0 back", fixedZeroEnable, 1);
		chk("precise_event_sampling back", samplingSuppressed, 0);
		chk("flag kept", globalCounterStatus[60], 1);
		$display("test optout_exit done");
	endtask
	task automatic t_optout_async();
		enter(1, 0);
		@(posedge mclk);
		asyncValid <= 1;
		eventPushes <= 1;
		sampleDue <= 1;
		eeeSampleDue <= 1;
		tick();
		rec("aex first", enterIp, asyncPointer);
		chk("aex sample", {samplePush, eventIp}, {1'b1, enterIp});
		@(posedge mclk);
		#1;
		rec("aex event", asyncPointer, eventTarget);
		chk("eee sample", {samplePush, eventIp}, {1'b1, asyncPointer});
		chk("aex mode", enclaveMode, EBPG_OUTSIDE);
		@(posedge mclk);
		eventPushes <= 0;
		eeeSampleDue <= 0;
		$display("test optout_async done");
	endtask
	task automatic t_optin();
		@(posedge mclk);
		statusClear <= 1;
		tick();
		enter(0, 1);
		rec("optin entry", enterIp, enterTarget);
		chk("optin ip", {samplePush, eventIp}, {1'b1, enterIp});
		chk("optin flag", globalCounterStatus[60], 0);
		chk("optin fix0", fixedZeroEnable, 1);
		@(posedge mclk);
		branchValid <= 1;
		branchFar <= 0;
		tick();
		rec("branch", branchIp, branchTarget);
		@(posedge mclk);
		branchValid <= 1;
		branchFar <= 1;
		branchFilterSelect <= 9'h100;
		tick();
		chk("far filtered", recPush, 0);
		@(posedge mclk);
		leafValid <= 1;
		leafSupervisor <= 0;
		leafKeyOrReport <= 1;
		tick();
		chk("key leaf", {samplePush, eventIp}, {1'b1, leafIp});
		@(posedge mclk);
		exitValid <= 1;
		tick();
		chk("exit filtered", recPush, 0);
		chk("optin exit ip", {samplePush, eventIp}, {1'b1, exitIp});
		@(posedge mclk);
		branchFilterSelect <= 9'h000;
		enter(0, 1);
		@(posedge mclk);
		asyncValid <= 1;
		tick();
		rec("optin aex", saveAreaIp, asyncPointer);
		chk("optin aex ip", {samplePush, eventIp}, {1'b1, saveAreaIp});
		$display("test optin done");
	endtask
	task automatic t_misc();
		@(posedge mclk);
		leafValid <= 1;
		leafSupervisor <= 1;
		leafKeyOrReport <= 0;
		tick();
		chk("sup leaf", {samplePush, eventIp}, {1'b1, leafIp});
		// opt-out entry with recording off, colliding with a software clear
		@(posedge mclk);
		recordEnable <= 0;
		statusClear <= 1;
		enterValid <= 1;
		enterOptOut <= 1;
		sampleDue <= 1;
		tick();
		chk("set beats clear", globalCounterStatus[60], 1);
		@(posedge mclk);
		recordEnable <= 1;
		leafValid <= 1;
		leafSupervisor <= 0;
		leafKeyOrReport <= 1;
		tick();
		chk("optout leaf", samplePush, 0);
		@(posedge mclk);
		branchValid <= 1;
		branchFar <= 0;
		tick();
		chk("optout branch", recPush, 0);
		@(posedge mclk);
		exitValid <= 1;
		tick();
		chk("no rec exit", recPush, 0);
		$display("test misc done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		{reset_n, enterValid, enterOptOut, exitValid, asyncValid, eventPushes} = 6'h00;
		{branchValid, branchFar, leafValid, leafSupervisor, leafKeyOrReport} = 5'h00;
		{sampleDue, eeeSampleDue, siblingOptOut, statusClear} = 4'h0;
		recordEnable = 1;
		{enterIp, enterTarget, exitIp, exitTarget} = {63'h1000, 63'h2000, 63'h3000, 63'h4000};
		{asyncPointer, saveAreaIp, eventTarget} = {63'h5000, 63'h6000, 63'h7000};
		{branchIp, branchTarget, leafIp} = {63'h8000, 63'h9000, 63'hA000};
		branchFilterSelect = 9'h000;
		siblingAllThread = 4'hF;
		siblingFixedAllThread = 3'h7;
		repeat (2) @(posedge mclk);
		reset_n <= 1;
		#1;
		chk("reset mode", enclaveMode, EBPG_OUTSIDE);
		chk("reset status", globalCounterStatus, 64'h0000_0000_0000_0000);
		t_optout_exit();
		t_optout_async();
		t_optin();
		t_misc();
		tally_and_finish();
	end
endmodule // ebpg_gating_bench
